// file: bench/monitor_scaling_scratch_regs_test.sv
/*
 * Self-checking bench for the monitor, scaling and scratch bank.
 * Assumes msr_bank and the host model; random data from a fixed seed.
 */
`timescale 1ns/1ps
`include "msr_defines.svh"

module monitor_scaling_scratch_regs_test;
    logic        clk, rst_n, wr, rd, e, rv, err;
    logic        m_ext, m_pre, m_ldo, m_buck;
    logic [6:0]  addr;
    logic [15:0] wdata, rdata, a, b, v, d;
    logic [4:0]  scale, c, core_scale;
    int          i, n_errors, cmp_count;
    bit          ok;

    msr_bank DUT (.I_REF_CLK(clk), .I_RST_N(rst_n), .I_REG_ADDR(addr), .I_REG_WR(wr),
        .I_REG_RD(rd), .I_REG_WDATA(wdata), .I_SCALE_CODE(scale), .O_REG_RDATA(rdata),
        .O_REG_RVALID(rv), .O_REG_ERR(err), .O_MON1_EXT(m_ext), .O_MON1_PRE(m_pre),
        .O_MON1_LDO_1(m_ldo), .O_MON1_BUCK_3(m_buck), .O_CORE_SCALE(core_scale));
    msr_host_model host (.i_clk(clk), .i_rdata(rdata), .i_rvalid(rv), .i_err(err),
        .o_addr(addr), .o_wr(wr), .o_rd(rd), .o_wdata(wdata));

    // ==========================================================
    // clock, checks and expectations
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    task automatic check(input string n, input logic [15:0] seen, input logic [15:0] x);
        cmp_count++;
        if (seen !== x) begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", n, x, seen);
        end
    endtask

    task automatic report_and_stop();
        if (n_errors == 0 && cmp_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    task automatic rd_chk(input string n, input logic [6:0] ad, input logic [15:0] x);
        logic [15:0] q;
        logic        qe;
        bit          qok;
        host.read(ad, q, qe, qok);
        check("read valid", 16'(qok), 16'h0001);
        check("read error", 16'(qe), 16'h0000);
        check(n, q, x);
    endtask

    // one-hot {ext, pre, ldo, buck}; reserved codes select nothing
    function automatic logic [3:0] mon_exp(input logic [2:0] k);
        case (k)
            3'h1: mon_exp = 4'h4;
            3'h2: mon_exp = 4'h2;
            3'h5: mon_exp = 4'h1;
            3'h3, 3'h4: mon_exp = 4'h0;
            default: mon_exp = 4'h8;
        endcase
    endfunction

    function automatic logic [15:0] scl_exp(input logic [4:0] k);
        scl_exp = 16'((k > `MSR_SCALE_MAX) ? `MSR_SCALE_MAX : k);
    endfunction

    // ==========================================================
    // main sequence
    initial begin
        void'($urandom(32'h6f65465d));
        n_errors = 0;
        cmp_count = 0;
        rst_n = 1'b0;
        scale = 5'h00;
        repeat (8) @(posedge clk);
        @(negedge clk) rst_n = 1'b1;
        for (i = 12; i < 16; i++) rd_chk("reset value", 7'(i), 16'h0000);
        check("reset monitor", {12'h0, m_ext, m_pre, m_ldo, m_buck}, 16'h0008);
        // every code, reserved bits set on odd passes
        for (i = 0; i < 8; i++) begin
            v = (16'($urandom) & 16'hFFF8) | 16'(i);
            host.write(`MSR_ADDR_MON_SEL, v, i[0], e);
            @(negedge clk);
            check("monitor out", {12'h0, m_ext, m_pre, m_ldo, m_buck}, 16'(mon_exp(i[2:0])));
            rd_chk("monitor readback", `MSR_ADDR_MON_SEL, 16'(i[2:0]));
        end
        // boundary codes first, then random 5-bit codes over the whole range
        for (i = 0; i < 12; i++) begin
            c = (i == 0) ? 5'h10 : (i == 1) ? 5'h1F : (i == 2) ? 5'h0F : 5'($urandom);
            @(negedge clk) scale = c;
            repeat (2) @(negedge clk);
            check("scale out", 16'(core_scale), scl_exp(c));
            rd_chk("scale readback", `MSR_ADDR_CORE_SCALE, scl_exp(c));
        end
        host.write(`MSR_ADDR_CORE_SCALE, 16'hFFFF, 1'b1, e);
        check("scale write error", 16'(e), 16'h0001);
        rd_chk("scale after write", `MSR_ADDR_CORE_SCALE, scl_exp(c));
        for (i = 0; i < 10; i++) begin
            a = (i == 0) ? 16'hFFFF : 16'($urandom);
            b = (i == 0) ? 16'h0000 : 16'($urandom);
            host.write(`MSR_ADDR_SCRATCH_A, a, 1'b1, e);
            host.write(`MSR_ADDR_SCRATCH_B, b, 1'b1, e);
            rd_chk("scratch a", `MSR_ADDR_SCRATCH_A, a);
            rd_chk("scratch b", `MSR_ADDR_SCRATCH_B, b);
        end
        host.read(7'h20, d, e, ok);
        check("unmapped data", d, 16'h0000);
        check("unmapped error", 16'(e), 16'h0001);
        // second reset in mid-run clears the stored words
        host.write(`MSR_ADDR_MON_SEL, 16'h0005, 1'b0, e);
        @(negedge clk) rst_n = 1'b0;
        @(negedge clk) rst_n = 1'b1;
        check("monitor out reset", {12'h0, m_ext, m_pre, m_ldo, m_buck}, 16'h0008);
        rd_chk("scratch a reset", `MSR_ADDR_SCRATCH_A, 16'h0000);
        rd_chk("scratch b reset", `MSR_ADDR_SCRATCH_B, 16'h0000);
        rd_chk("monitor reset", `MSR_ADDR_MON_SEL, 16'h0000);
        report_and_stop();
    end

    // hang guard: counts as a mismatch
    initial begin
        repeat (20000) @(posedge clk);
        n_errors++;
        report_and_stop();
    end
endmodule

// file: bench/msr_host_model.sv
/*
 * Host controller model: issues single-word register accesses on the
 * bank's access port, the way the serial front end hands them over.
 * Assumes one clock, drives on its falling edge, one access at a time.
 */
`timescale 1ns/1ps
`include "msr_defines.svh"

module msr_host_model (
    input  wire logic        i_clk,
    input  wire logic [15:0] i_rdata,
    input  wire logic        i_rvalid,
    input  wire logic        i_err,
    output logic      [6:0]  o_addr,
    output logic             o_wr,
    output logic             o_rd,
    output logic      [15:0] o_wdata
);
    // ==========================================================
    // idle levels and access tasks
    initial begin
        o_addr = 7'h00;
        o_wr = 1'b0;
        o_rd = 1'b0;
        o_wdata = 16'h0000;
    end

    // raw set: reserved bits go out as given, to probe the device
    task automatic write(input logic [6:0] a, input logic [15:0] d, input bit raw,
                         output logic err);
        @(negedge i_clk);
        o_addr = a;
        o_wdata = (a == `MSR_ADDR_MON_SEL && !raw) ? {13'h0, d[2:0]} : d;
        o_wr = 1'b1;
        @(negedge i_clk);
        o_wr = 1'b0;
        // released lines must not keep their last value
        o_addr = ~a;
        o_wdata = ~o_wdata;
        err = i_err;
    endtask

    task automatic read(input logic [6:0] a, output logic [15:0] d, output logic err,
                        output bit ok);
        @(negedge i_clk);
        o_addr = a;
        o_rd = 1'b1;
        @(negedge i_clk);
        o_rd = 1'b0;
        o_addr = ~a;
        ok = (i_rvalid === 1'b1);
        d = i_rdata;
        err = i_err;
    endtask
endmodule

// file: core/msr_bank.sv
/*
 * Monitor source selector, read-only core buck scaling offset and two
 * scratch words, reached over a simple word access port.
 * Assumes the serial front end delivers one-cycle read and write
 * strobes, already CRC-checked, synchronous to I_REF_CLK.
 */
`timescale 1ns/1ps
`include "msr_defines.svh"

module msr_bank #(
    parameter int ADDR_W = `MSR_ADDR_W
) (
    input  wire logic                    I_REF_CLK,
    input  wire logic                    I_RST_N,
    input  wire logic [ADDR_W-1:0]       I_REG_ADDR,
    input  wire logic                    I_REG_WR,
    input  wire logic                    I_REG_RD,
    input  wire logic [`MSR_DATA_W-1:0]  I_REG_WDATA,
    input  wire logic [`MSR_SCALE_W-1:0] I_SCALE_CODE,
    output logic      [`MSR_DATA_W-1:0]  O_REG_RDATA,
    output logic                         O_REG_RVALID,
    output logic                         O_REG_ERR,
    output logic                         O_MON1_EXT,
    output logic                         O_MON1_PRE,
    output logic                         O_MON1_LDO_1,
    output logic                         O_MON1_BUCK_3,
    output logic      [`MSR_SCALE_W-1:0] O_CORE_SCALE
);

    // ==========================================================
    // elaboration check
    generate
        if (ADDR_W < `MSR_ADDR_W) begin : g_bad_addr_w
            $error("msr_bank: ADDR_W too narrow for the register indices");
        end
    endgenerate

    // ==========================================================
    // address decode
    logic                         hit_mon;
    logic                         hit_scale;
    logic                         hit_a;
    logic                         hit_b;
    logic                         hit_any;
    logic [`MSR_MON_SEL_W-1:0]    mon_sel;
    logic [`MSR_DATA_W-1:0]       scratch_a;
    logic [`MSR_DATA_W-1:0]       scratch_b;
    logic [`MSR_SCALE_W-1:0]      scale;
    logic [`MSR_SCALE_W-1:0]      next_scale;
    logic [`MSR_DATA_W-1:0]       next_rdata;

    assign hit_mon   = (I_REG_ADDR == ADDR_W'(`MSR_ADDR_MON_SEL));
    assign hit_scale = (I_REG_ADDR == ADDR_W'(`MSR_ADDR_CORE_SCALE));
    assign hit_a     = (I_REG_ADDR == ADDR_W'(`MSR_ADDR_SCRATCH_A));
    assign hit_b     = (I_REG_ADDR == ADDR_W'(`MSR_ADDR_SCRATCH_B));
    assign hit_any   = hit_mon | hit_scale | hit_a | hit_b;

    // ==========================================================
    // writable fields
    // selector storage
    msr_reg_cell #(
        .WIDTH (`MSR_MON_SEL_W),
        .RST   (`MSR_MON_SEL_RST)
    ) u_mon_sel (
        .i_clk   (I_REF_CLK),
        .i_rst_n (I_RST_N),
        .i_wr    (I_REG_WR & hit_mon),
        .i_wdata (I_REG_WDATA[`MSR_MON_SEL_LSB +: `MSR_MON_SEL_W]),
        .o_q     (mon_sel)
    );

    msr_reg_cell #(
        .WIDTH (`MSR_DATA_W),
        .RST   (`MSR_SCRATCH_RST)
    ) u_scratch_a (
        .i_clk   (I_REF_CLK),
        .i_rst_n (I_RST_N),
        .i_wr    (I_REG_WR & hit_a),
        .i_wdata (I_REG_WDATA),
        .o_q     (scratch_a)
    );

    msr_reg_cell #(
        .WIDTH (`MSR_DATA_W),
        .RST   (`MSR_SCRATCH_RST)
    ) u_scratch_b (
        .i_clk   (I_REF_CLK),
        .i_rst_n (I_RST_N),
        .i_wr    (I_REG_WR & hit_b),
        .i_wdata (I_REG_WDATA),
        .o_q     (scratch_b)
    );

    // ==========================================================
    // read-only scaling offset
    // clamp to minus 100 mV
    // codes above the last step have no meaning, so they never reach software
    always_comb begin
        if (I_SCALE_CODE > `MSR_SCALE_MAX) begin
            next_scale = `MSR_SCALE_MAX;
        end else begin
            next_scale = I_SCALE_CODE;
        end
    end

    always_ff @(posedge I_REF_CLK) begin
        if (!I_RST_N) begin
            scale <= `MSR_SCALE_RST;
        end else begin
            scale <= next_scale;
        end
    end

    always_ff @(posedge I_REF_CLK) begin
        if (!I_RST_N) begin
            O_CORE_SCALE <= `MSR_SCALE_RST;
        end else begin
            O_CORE_SCALE <= scale;
        end
    end

    // ==========================================================
    // monitor-one routing
    // source decode
    // reserved codes select nothing rather than guess a regulator
    always_ff @(posedge I_REF_CLK) begin
        if (!I_RST_N) begin
            O_MON1_EXT    <= 1'b1;
            O_MON1_PRE    <= 1'b0;
            O_MON1_LDO_1  <= 1'b0;
            O_MON1_BUCK_3 <= 1'b0;
        end else begin
            O_MON1_EXT    <= 1'b0;
            O_MON1_PRE    <= 1'b0;
            O_MON1_LDO_1  <= 1'b0;
            O_MON1_BUCK_3 <= 1'b0;
            case (msr_pkg::msr_src_e'(mon_sel))
                msr_pkg::MSR_SRC_EXT:     O_MON1_EXT    <= 1'b1;
                msr_pkg::MSR_SRC_EXT_HI0: O_MON1_EXT    <= 1'b1;
                msr_pkg::MSR_SRC_EXT_HI1: O_MON1_EXT    <= 1'b1;
                msr_pkg::MSR_SRC_PRE:     O_MON1_PRE    <= 1'b1;
                msr_pkg::MSR_SRC_LDO_1:   O_MON1_LDO_1  <= 1'b1;
                msr_pkg::MSR_SRC_BUCK_3:  O_MON1_BUCK_3 <= 1'b1;
                default:                  O_MON1_EXT    <= 1'b0;
            endcase
        end
    end

    // ==========================================================
    // read path
    // reserved read bits zero
    always_comb begin
        next_rdata = '0;
        if (hit_mon) begin
            next_rdata[`MSR_MON_SEL_LSB +: `MSR_MON_SEL_W] = mon_sel;
        end else if (hit_scale) begin
            next_rdata[`MSR_SCALE_LSB +: `MSR_SCALE_W] = scale;
        end else if (hit_a) begin
            next_rdata = scratch_a;
        end else if (hit_b) begin
            next_rdata = scratch_b;
        end
    end

    // read data stands until the next read strobe
    always_ff @(posedge I_REF_CLK) begin
        if (!I_RST_N) begin
            O_REG_RDATA <= '0;
        end else if (I_REG_RD) begin
            O_REG_RDATA <= next_rdata;
        end
    end

    always_ff @(posedge I_REF_CLK) begin
        if (!I_RST_N) begin
            O_REG_RVALID <= 1'b0;
        end else begin
            O_REG_RVALID <= I_REG_RD;
        end
    end

    // unmapped index, or a write to the read-only word
    always_ff @(posedge I_REF_CLK) begin
        if (!I_RST_N) begin
            O_REG_ERR <= 1'b0;
        end else begin
            O_REG_ERR <= ((I_REG_RD | I_REG_WR) & ~hit_any) | (I_REG_WR & hit_scale);
        end
    end

    // ==========================================================
    // checks
    mon_buck_route_a: assert property (
        @(posedge I_REF_CLK) disable iff (!I_RST_N)
        (I_REG_WR && hit_mon && I_REG_WDATA[2:0] == 3'b101) |=> ##1 O_MON1_BUCK_3 && !O_MON1_EXT
    ) else $error("buck three not routed after selector write");

    mon_reserved_idle_a: assert property (
        @(posedge I_REF_CLK) disable iff (!I_RST_N)
        (I_REG_WR && hit_mon && (I_REG_WDATA[2:0] == 3'b011 || I_REG_WDATA[2:0] == 3'b100))
        |=> ##1 !(O_MON1_EXT || O_MON1_PRE || O_MON1_LDO_1 || O_MON1_BUCK_3)
    ) else $error("reserved selector code routed a source");

    mon_ext_high_a: assert property (
        @(posedge I_REF_CLK) disable iff (!I_RST_N)
        (I_REG_WR && hit_mon && I_REG_WDATA[2:1] == 2'b11) |=> ##1 O_MON1_EXT
    ) else $error("codes 11x must select external regulator");

    scale_read_only_a: assert property (
        @(posedge I_REF_CLK) disable iff (!I_RST_N)
        (I_REG_WR && hit_scale && I_SCALE_CODE == $past(I_SCALE_CODE)) |=> scale == $past(scale)
    ) else $error("scaling field changed by a host write");

    scale_write_err_a: assert property (
        @(posedge I_REF_CLK) disable iff (!I_RST_N)
        (I_REG_WR && hit_scale) |=> O_REG_ERR
    ) else $error("write to read-only scaling word not flagged");

    scale_clamp_a: assert property (
        @(posedge I_REF_CLK) disable iff (!I_RST_N)
        O_REG_RVALID && $past(hit_scale) |-> O_REG_RDATA <= 16'h0010
    ) else $error("scaling readback beyond minus 100 mV");

    scratch_a_back_a: assert property (
        @(posedge I_REF_CLK) disable iff (!I_RST_N)
        (I_REG_WR && hit_a) ##1 (I_REG_RD && hit_a && !I_REG_WR)
        |=> O_REG_RDATA == $past(I_REG_WDATA, 2)
    ) else $error("scratch A readback differs from written value");

    scratch_b_hold_a: assert property (
        @(posedge I_REF_CLK) disable iff (!I_RST_N)
        !(I_REG_WR && hit_b) |=> scratch_b == $past(scratch_b)
    ) else $error("scratch B changed without a write");

    reserved_zero_a: assert property (
        @(posedge I_REF_CLK) disable iff (!I_RST_N)
        (I_REG_RD && hit_mon) |=> O_REG_RVALID && O_REG_RDATA[15:3] == 13'h0000
    ) else $error("reserved selector bits read nonzero");

    unmapped_err_a: assert property (
        @(posedge I_REF_CLK) disable iff (!I_RST_N)
        (I_REG_RD && !hit_any) |=> O_REG_ERR && O_REG_RDATA == 16'h0000
    ) else $error("unmapped read not flagged or not zero");

endmodule

// file: core/msr_defines.svh
/*
 * Offsets, field positions, widths and reset values of the monitor,
 * scaling and scratch register bank.
 * Assumes the serial front end hands over data bits 23..8 of a frame
 * as a 16-bit word whose bit 0 is frame bit 8.
 */
`ifndef MSR_DEFINES_SVH
`define MSR_DEFINES_SVH

// ==========================================================
// register indices on the internal access port
`define MSR_ADDR_W            7
`define MSR_ADDR_MON_SEL      7'h0C
`define MSR_ADDR_CORE_SCALE   7'h0D
`define MSR_ADDR_SCRATCH_A    7'h0E
`define MSR_ADDR_SCRATCH_B    7'h0F

// ==========================================================
// field layout inside the 16-bit data word
`define MSR_DATA_W            16
`define MSR_MON_SEL_LSB       0
`define MSR_MON_SEL_W         3
`define MSR_SCALE_LSB         0
`define MSR_SCALE_W           5
`define MSR_SCALE_MAX         5'h10

// ==========================================================
// power-on reset values
`define MSR_MON_SEL_RST       3'h0
`define MSR_SCALE_RST         5'h00
`define MSR_SCRATCH_RST       16'h0000

`endif

// file: core/msr_pkg.sv
/*
 * Types shared by the monitor, scaling and scratch register bank.
 * Assumes msr_defines.svh holds every number.
 */
package msr_pkg;

    // ==========================================================
    // monitor-one source codes
    typedef enum logic [2:0] {
        MSR_SRC_EXT      = 3'b000,
        MSR_SRC_PRE      = 3'b001,
        MSR_SRC_LDO_1    = 3'b010,
        MSR_SRC_RSVD3    = 3'b011,
        MSR_SRC_RSVD4    = 3'b100,
        MSR_SRC_BUCK_3   = 3'b101,
        MSR_SRC_EXT_HI0  = 3'b110,
        MSR_SRC_EXT_HI1  = 3'b111
    } msr_src_e;

endpackage

// file: core/msr_reg_cell.sv
/*
 * One writable storage field with synchronous reset.
 * Assumes a single-cycle write strobe from the register decoder.
 */
`timescale 1ns/1ps

module msr_reg_cell #(
    parameter int              WIDTH = 16,
    parameter logic [WIDTH-1:0] RST  = '0
) (
    input  wire logic             i_clk,
    input  wire logic             i_rst_n,
    input  wire logic             i_wr,
    input  wire logic [WIDTH-1:0] i_wdata,
    output logic      [WIDTH-1:0] o_q
);

    // ==========================================================
    // storage
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            o_q <= RST;
        end else if (i_wr) begin
            o_q <= i_wdata;
        end
    end

endmodule
